// File: core/byte_index.sv
// Purpose: one byte index counter with done and half detection
// Assumes: step of 1 to 4 bytes per bus transfer
// Notes: a count of zero stands for 65536 bytes
`timescale 1ns/1ps
module byte_index (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clear_i,
    input wire logic step_i,
    input wire logic [dma_size_pkg::STEP_W-1:0] bytes_i,
    input wire logic [dma_size_pkg::SIZE_W-1:0] count_i,
    output logic [dma_size_pkg::SIZE_W-1:0] index_o,
    output logic done_o,
    output logic half_o
);
    logic [16:0] limit;
    logic [16:0] sum;
    logic [16:0] half;

    function automatic logic [16:0] byte_limit(input logic [15:0] c);
        byte_limit = (c == 16'h0000) ? dma_size_pkg::FULL_COUNT : {1'b0, c};
    endfunction

    always_comb begin
        limit = byte_limit(count_i);
        half = {1'b0, limit[16:1]};
        sum = {1'b0, index_o} + {14'h0000, bytes_i};
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            index_o <= 16'h0000;
            done_o <= 1'b0;
            half_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            half_o <= 1'b0;
            if (clear_i) begin
                index_o <= 16'h0000;
            end else if (step_i) begin
                if (sum >= limit) begin
                    index_o <= 16'h0000;
                    done_o <= 1'b1;
                end else begin
                    index_o <= sum[15:0];
                end
                if ({1'b0, index_o} < half && sum >= half) begin
                    half_o <= 1'b1;
                end
            end
        end
    end
endmodule

// File: core/dma_channel_size_pointer.sv
// Purpose: addressing and progress part of one dma channel
// Assumes: apb register access, one clock, transfers reported by the bus engine
// Notes: pointers are read only, events feed a sticky status with mask
`timescale 1ns/1ps
module dma_channel_size_pointer (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic src_step_i,
    input wire logic [2:0] src_bytes_i,
    input wire logic dst_step_i,
    input wire logic [2:0] dst_bytes_i,
    input wire logic [7:0] moved_byte_i,
    output logic [31:0] destination_start_address_o,
    output logic [15:0] source_byte_index_o,
    output logic [15:0] destination_byte_index_o,
    output logic pattern_match_o,
    output logic block_complete_o,
    output logic irq_o
);
    logic rst_meta_reg;
    logic rst_n_reg;
    logic [31:0] dest_start_reg;
    logic [15:0] src_count_reg;
    logic [15:0] dst_count_reg;
    logic [7:0] match_reg;
    logic pattern_en_reg;
    logic [3:0] stat_reg;
    logic [3:0] mask_reg;
    logic [3:0] stat_next;
    logic [3:0] clear_bits;
    logic [31:0] rdata_next;
    logic [31:0] ctrl_view;
    logic wr_en;
    logic rd_en;
    logic setup_phase;
    logic access_phase;
    logic known_addr;
    logic wr_dest;
    logic wr_src_size;
    logic wr_dst_size;
    logic wr_match;
    logic wr_ctrl;
    logic wr_mask;
    logic wr_stat;
    logic src_done;
    logic src_half;
    logic dst_done;
    logic match_hit;
    logic src_larger;
    logic block_done;
    logic [3:0] events;
    logic any_step;
    dma_size_pkg::chan_state_t state_reg;
    dma_size_pkg::chan_state_t state_next;

    // zero in a count field stands for the full 64 KiB span, so compare on 17 bits
    function automatic logic [16:0] span_of(input logic [15:0] count);
        span_of = (count == 16'h0000) ? dma_size_pkg::FULL_COUNT : {1'b0, count};
    endfunction

    // one place decides what an address hit means, so every write strobe agrees; the read map decodes paddr_i in its own case
    function automatic logic is_offset(input logic [7:0] addr, input logic [7:0] offset);
        is_offset = (addr == offset);
    endfunction

    // unimplemented upper bits of the size, pointer and match reads are filled here; ctrl_view and the status and mask reads pad their own
    function automatic logic [31:0] widen16(input logic [15:0] value);
        widen16 = {16'h0000, value};
    endfunction

    function automatic logic [31:0] widen8(input logic [7:0] value);
        widen8 = {24'h000000, value};
    endfunction

    // two flops so that release of the pin reset is seen on one edge everywhere
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // zero wait states: the answer comes in the first access cycle
    assign setup_phase = psel_i && !penable_i;
    assign access_phase = psel_i && penable_i;
    assign wr_en = access_phase && pwrite_i;
    assign rd_en = setup_phase && !pwrite_i;
    assign pready_o = access_phase;
    assign pslverr_o = access_phase && !known_addr;

    // pointer offsets have no write strobe, so writes there fall away
    always_comb begin
        wr_dest = wr_en && is_offset(paddr_i, dma_size_pkg::OFF_DEST_START);
        wr_src_size = wr_en && is_offset(paddr_i, dma_size_pkg::OFF_SRC_SIZE);
        wr_dst_size = wr_en && is_offset(paddr_i, dma_size_pkg::OFF_DEST_SIZE);
        wr_match = wr_en && is_offset(paddr_i, dma_size_pkg::OFF_MATCH);
        wr_ctrl = wr_en && is_offset(paddr_i, dma_size_pkg::OFF_CTRL);
        wr_mask = wr_en && is_offset(paddr_i, dma_size_pkg::OFF_IRQ_MASK);
        wr_stat = wr_en && is_offset(paddr_i, dma_size_pkg::OFF_IRQ_STAT);
    end

    // full word kept; the address is not checked, that is up to software
    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            dest_start_reg <= dma_size_pkg::RESET_WORD;
        end else if (wr_dest) begin
            dest_start_reg <= pwdata_i;
        end
    end

    // only the low half is stored
    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            src_count_reg <= dma_size_pkg::RESET_WORD[15:0];
        end else if (wr_src_size) begin
            src_count_reg <= pwdata_i[15:0];
        end
    end

    // only the low half is stored
    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            dst_count_reg <= dma_size_pkg::RESET_WORD[15:0];
        end else if (wr_dst_size) begin
            dst_count_reg <= pwdata_i[15:0];
        end
    end

    // only the low byte is stored
    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            match_reg <= dma_size_pkg::RESET_WORD[7:0];
        end else if (wr_match) begin
            match_reg <= pwdata_i[7:0];
        end
    end

    // pattern mode switch
    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pattern_en_reg <= 1'b0;
        end else if (wr_ctrl) begin
            pattern_en_reg <= pwdata_i[dma_size_pkg::CTRL_PATTERN_EN];
        end
    end

    // interrupt mask, same layout as the status
    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            mask_reg <= 4'h0;
        end else if (wr_mask) begin
            mask_reg <= pwdata_i[dma_size_pkg::IRQ_W-1:0];
        end
    end

    // an event in the same cycle as a software clear wins, so no event is lost
    always_comb begin
        clear_bits = 4'h0;
        if (wr_stat) begin
            clear_bits = pwdata_i[dma_size_pkg::IRQ_W-1:0];
        end
        stat_next = (stat_reg & ~clear_bits) | events;
    end

    // sticky status
    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            stat_reg <= 4'h0;
        end else begin
            stat_reg <= stat_next;
        end
    end

    // registered so the line never glitches; it trails the status by one cycle
    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(stat_reg & mask_reg);
        end
    end

    // event map
    always_comb begin
        events = 4'h0;
        events[dma_size_pkg::IRQ_SRC_DONE] = src_done;
        events[dma_size_pkg::IRQ_SRC_HALF] = src_half;
        events[dma_size_pkg::IRQ_DEST_DONE] = dst_done;
        events[dma_size_pkg::IRQ_BLOCK] = block_done;
    end

    // only a byte the source side really moved is compared; outside pattern mode the field is ignored
    assign match_hit = pattern_en_reg && src_step_i && (moved_byte_i == match_reg);

    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pattern_match_o <= 1'b0;
        end else begin
            pattern_match_o <= match_hit;
        end
    end

    // the longer side or a registered pattern match ends the block; equal sizes count on the source side
    assign src_larger = span_of(src_count_reg) >= span_of(dst_count_reg);
    assign block_done = (src_larger ? src_done : dst_done) || pattern_match_o;

    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            block_complete_o <= 1'b0;
        end else begin
            block_complete_o <= block_done;
        end
    end

    // a pattern detect takes priority over a step that lands in the same cycle
    // limitation: a step wider than the bytes left is cut at the count, the rest is lost
    // destination half is not an event here, so its output is left open
    byte_index src_index_i (
        .clk_i(clk_i),
        .rst_n_i(rst_n_reg),
        .clear_i(match_hit),
        .step_i(src_step_i),
        .bytes_i(src_bytes_i),
        .count_i(src_count_reg),
        .index_o(source_byte_index_o),
        .done_o(src_done),
        .half_o(src_half)
    );

    byte_index dst_index_i (
        .clk_i(clk_i),
        .rst_n_i(rst_n_reg),
        .clear_i(1'b0),
        .step_i(dst_step_i),
        .bytes_i(dst_bytes_i),
        .count_i(dst_count_reg),
        .index_o(destination_byte_index_o),
        .done_o(dst_done),
        .half_o()
    );

    // progress view for software; gray order so a read racing a change sees a neighbour
    assign any_step = src_step_i || dst_step_i;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dma_size_pkg::CH_IDLE: begin
                if (any_step) begin
                    state_next = dma_size_pkg::CH_RUN;
                end
            end
            dma_size_pkg::CH_RUN: begin
                if (block_done) begin
                    state_next = dma_size_pkg::CH_DONE;
                end
            end
            dma_size_pkg::CH_DONE: begin
                if (any_step) begin
                    state_next = dma_size_pkg::CH_RUN;
                end
            end
            default: begin
                state_next = dma_size_pkg::CH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= dma_size_pkg::CH_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // read map; unknown offsets read zero and answer with an error
    assign ctrl_view = {29'h0, state_reg, pattern_en_reg};

    always_comb begin
        rdata_next = 32'h0000_0000;
        known_addr = 1'b1;
        case (paddr_i)
            dma_size_pkg::OFF_DEST_START: begin
                rdata_next = dest_start_reg;
            end
            dma_size_pkg::OFF_SRC_SIZE: begin
                rdata_next = widen16(src_count_reg);
            end
            dma_size_pkg::OFF_DEST_SIZE: begin
                rdata_next = widen16(dst_count_reg);
            end
            dma_size_pkg::OFF_SRC_POS: begin
                rdata_next = widen16(source_byte_index_o);
            end
            dma_size_pkg::OFF_DEST_POS: begin
                rdata_next = widen16(destination_byte_index_o);
            end
            dma_size_pkg::OFF_MATCH: begin
                rdata_next = widen8(match_reg);
            end
            dma_size_pkg::OFF_CTRL: begin
                rdata_next = ctrl_view;
            end
            dma_size_pkg::OFF_IRQ_STAT: begin
                rdata_next = {28'h0, stat_reg};
            end
            dma_size_pkg::OFF_IRQ_MASK: begin
                rdata_next = {28'h0, mask_reg};
            end
            default: begin
                known_addr = 1'b0;
            end
        endcase
    end

    // read data is captured in the setup cycle and stands through the access cycle
    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            prdata_o <= dma_size_pkg::RESET_WORD;
        end else if (rd_en) begin
            prdata_o <= rdata_next;
        end
    end

    assign destination_start_address_o = dest_start_reg;
endmodule

// File: core/dma_size_pkg.sv
// Purpose: constants for the channel size and pointer block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
package dma_size_pkg;
    localparam logic [7:0] OFF_DEST_START = 8'h00;
    localparam logic [7:0] OFF_SRC_SIZE = 8'h04;
    localparam logic [7:0] OFF_DEST_SIZE = 8'h08;
    localparam logic [7:0] OFF_SRC_POS = 8'h0c;
    localparam logic [7:0] OFF_DEST_POS = 8'h10;
    localparam logic [7:0] OFF_MATCH = 8'h14;
    localparam logic [7:0] OFF_CTRL = 8'h18;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
    localparam int SIZE_W = 16;
    localparam int MATCH_W = 8;
    localparam int STEP_W = 3;
    localparam int IRQ_W = 4;
    localparam int IRQ_SRC_DONE = 0;
    localparam int IRQ_SRC_HALF = 1;
    localparam int IRQ_DEST_DONE = 2;
    localparam int IRQ_BLOCK = 3;
    localparam int CTRL_PATTERN_EN = 0;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [16:0] FULL_COUNT = 17'h1_0000;
    typedef enum logic [1:0] {
        CH_IDLE = 2'b00,
        CH_RUN = 2'b01,
        CH_DONE = 2'b11
    } chan_state_t;
endpackage

// File: testbench/dma_sva.sv
// Purpose: port checker
// Assumes: apb answer on pready
// Notes: bound with .*
`timescale 1ns/1ps
module dma_sva(input logic clk_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, src_step_i, dst_step_i,
    input logic pattern_match_o, input logic [7:0] paddr_i, input logic [31:0] prdata_o,
    input logic [15:0] source_byte_index_o, destination_byte_index_o);
    wire rd = psel_i && penable_i && pready_o && !pwrite_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_src_rst: assert property ($rose(resetn_i) |-> source_byte_index_o == 0) else $error("src idx");
    a_dst_rst: assert property ($rose(resetn_i) |-> destination_byte_index_o == 0) else $error("dst idx");
    a_size_top: assert property (rd && paddr_i inside {4, 8, 12, 16} |-> prdata_o[31:16] == 0) else $error("hi");
    a_match_top: assert property (rd && paddr_i == 20 |-> prdata_o[31:8] == 0) else $error("match hi");
    a_src_cause: assert property ($changed(source_byte_index_o) |-> $past(src_step_i) || $past(pattern_match_o)
        || pattern_match_o) else $error("src move");
    a_dst_cause: assert property ($changed(destination_byte_index_o) |-> $past(dst_step_i)) else $error("dst move");
    c_read: cover property (rd);
    c_step: cover property (src_step_i);
    c_half: cover property (source_byte_index_o == 2);
endmodule
bind dma_channel_size_pointer dma_sva dma_sva_i(.*);

// File: testbench/mem_model.sv
// Purpose: bus side stand-in moving bytes
// Assumes: one byte per transfer
// Notes: random stalls between transfers
`timescale 1ns/1ps
module mem_model(input logic clk_i, go_i, output logic step_o = 0, output logic [2:0] bytes_o,
    output logic [7:0] data_o = 0, output logic busy_o);
    logic [7:0] left = 0;
    assign bytes_o = 3'd1;
    assign busy_o = left != 0 || step_o;
    always @(posedge clk_i) begin
        step_o <= 0;
        if (go_i) left <= 2;
        else if (left != 0 && $urandom_range(1) == 1) begin
            step_o <= 1;
            left <= left - 1;
            data_o <= ~data_o;
        end
    end
endmodule

// File: testbench/testbench.sv
// Purpose: register and progress checks
// Assumes: status bits 0..3 as in the package
// Notes: reads are scored from a queue
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; $display("BAD %0t mismatch", $time); end end
module testbench;
    logic clk_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, go = 0, busy, src_step_i, dst_step_i;
    logic pready_o, pslverr_o, pattern_match_o, block_complete_o, irq_o;
    logic [2:0] src_bytes_i, dst_bytes_i;
    logic [7:0] paddr_i = 0, moved_byte_i;
    logic [15:0] source_byte_index_o, destination_byte_index_o;
    logic [31:0] pwdata_i = 0, r, prdata_o, destination_start_address_o, q[$];
    int n_fail = 0, num_checks = 0, n_pat = 0, n_blk = 0;
    assign dst_step_i = src_step_i;
    assign dst_bytes_i = src_bytes_i;
    dma_channel_size_pointer dma_channel_size_pointer_i(.*);
    mem_model mem_model_i(.clk_i(clk_i), .go_i(go), .step_o(src_step_i), .bytes_o(src_bytes_i),
        .data_o(moved_byte_i), .busy_o(busy));
    initial forever #50 clk_i = ~clk_i;
    always @(posedge clk_i) if (psel_i && penable_i && pready_o === 1'b1) begin
        `CHK(pslverr_o, paddr_i > dma_size_pkg::OFF_IRQ_MASK)
        if (!pwrite_i) `CHK(prdata_o, q.pop_front())
    end
    always @(posedge clk_i) begin
        n_pat += int'(pattern_match_o === 1'b1);
        n_blk += int'(block_complete_o === 1'b1);
    end
    task end_sim;
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        if (!w) q.push_back(d);
        psel_i <= 1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
        @(posedge clk_i) penable_i <= 1;
        do @(posedge clk_i); while (pready_o !== 1'b1 && ++k < 50);
        if (k == 50) begin n_fail++; end_sim; end
        psel_i <= 0; penable_i <= 0;
        @(posedge clk_i);
    endtask
    task run;
        go <= 1;
        @(posedge clk_i) go <= 0;
        @(posedge clk_i);
        for (int k = 0; k < 99 && busy !== 1'b0; k++) @(posedge clk_i);
        if (busy !== 1'b0) begin n_fail++; end_sim; end
    endtask
    initial begin
        void'($urandom(33));
        repeat (3) @(posedge clk_i);
        resetn_i <= 1;
        repeat (3) @(posedge clk_i);
        for (int a = 0; a < 24; a += 4) apb(0, a, 0);
        apb(1, 4, '1); apb(0, 4, 32'hffff); apb(1, 8, '1); apb(0, 8, 32'hffff);
        apb(1, 12, '1); apb(0, 12, 0); apb(1, 20, '1); apb(0, 20, 32'hff);
        r = $urandom;
        apb(1, 0, r); apb(0, 0, r); `CHK(destination_start_address_o, r)
        apb(1, 4, 4); apb(1, 8, 4); run; apb(0, 12, 2); apb(0, 16, 2);
        run; apb(0, 12, 0); apb(0, 16, 0); apb(0, 28, 32'hf);
        apb(1, 28, 32'hf); apb(0, 28, 0); `CHK(irq_o, 1'b0)
        `CHK(n_blk, 1) `CHK(n_pat, 0)
        apb(1, 32, 8); apb(1, 20, 32'hff); apb(1, 24, 1); run; `CHK(n_pat, 1)
        apb(0, 12, 1); apb(0, 16, 2); apb(0, 28, 8); `CHK(irq_o, 1'b1)
        `CHK(n_blk, 2) apb(0, 36, 0);
        end_sim;
    end
endmodule
